// file: hdl/dma_reqsel_pkg.sv
// Overview of operation
// - Six-bit request-type code per channel; upper register bits read zero, ignore writes.
// - Code 000000 paces from external request pin, acknowledged on acknowledge pin.
// - Code 000001 paces from NAND request, memory to memory addressing.
// - Code 000010 selects ECC encoder request, 000011 ECC decoder request.
// - Code 001000 self-requests continuously, memory to memory, ignoring detect interval.
// - Code 001001 paces from transport-stream receive FIFO-full, FIFO to memory.
// - Codes 001110/001111 select fourth serial port transmit-empty/receive-full.
// - Codes 010000/010001 select third serial port transmit-empty/receive-full.
// - Codes 010010/010011 select second serial port transmit-empty/receive-full.
// - Codes 010100/010101 select first serial port transmit-empty/receive-full.
// - Codes 010110/010111 select first sync serial port transmit-empty/receive-full.
// - Codes 011000/011001 select audio interface transmit-empty/receive-full.
// - Codes 011010/011011 select first card controller transmit-empty/receive-full.
// - Code 011100 paces from the channel's timer overflow, memory to memory.
// - Code 011101 paces from the SAR converter request, converter to memory.
// - Codes 011110/011111 select second card controller transmit-empty/receive-full.
// - Codes 100000/100001 select second sync serial port transmit-empty/receive-full.
// - Code 100010 selects the PCM interface transmit-empty request.
// - Code 100011 selects PCM receive-full request; all other codes are reserved.
package dma_reqsel_pkg;
   localparam int NUM_CHANNELS_DEFAULT = 6;
   localparam int REG_WIDTH = 32;
   localparam int RT_WIDTH = 6;
   localparam int RT_LSB = 0;
   localparam int RT_MSB = 5;
   localparam logic [RT_WIDTH-1:0] RT_RESET = 6'h00;
   localparam logic [REG_WIDTH-RT_WIDTH-1:0] RT_UPPER_ZERO = 26'h000_0000;

   localparam logic [RT_WIDTH-1:0] RT_EXT_PIN = 6'h00;
   localparam logic [RT_WIDTH-1:0] RT_NAND = 6'h01;
   localparam logic [RT_WIDTH-1:0] RT_ECC_ENC = 6'h02;
   localparam logic [RT_WIDTH-1:0] RT_ECC_DEC = 6'h03;
   localparam logic [RT_WIDTH-1:0] RT_AUTO = 6'h08;
   localparam logic [RT_WIDTH-1:0] RT_TS_RX = 6'h09;
   localparam logic [RT_WIDTH-1:0] RT_SER3_TX = 6'h0e;
   localparam logic [RT_WIDTH-1:0] RT_SER3_RX = 6'h0f;
   localparam logic [RT_WIDTH-1:0] RT_SER2_TX = 6'h10;
   localparam logic [RT_WIDTH-1:0] RT_SER2_RX = 6'h11;
   localparam logic [RT_WIDTH-1:0] RT_SER1_TX = 6'h12;
   localparam logic [RT_WIDTH-1:0] RT_SER1_RX = 6'h13;
   localparam logic [RT_WIDTH-1:0] RT_SER0_TX = 6'h14;
   localparam logic [RT_WIDTH-1:0] RT_SER0_RX = 6'h15;
   localparam logic [RT_WIDTH-1:0] RT_SSP0_TX = 6'h16;
   localparam logic [RT_WIDTH-1:0] RT_SSP0_RX = 6'h17;
   localparam logic [RT_WIDTH-1:0] RT_AUD_TX = 6'h18;
   localparam logic [RT_WIDTH-1:0] RT_AUD_RX = 6'h19;
   localparam logic [RT_WIDTH-1:0] RT_CARD0_TX = 6'h1a;
   localparam logic [RT_WIDTH-1:0] RT_CARD0_RX = 6'h1b;
   localparam logic [RT_WIDTH-1:0] RT_TIMER = 6'h1c;
   localparam logic [RT_WIDTH-1:0] RT_ADC = 6'h1d;
   localparam logic [RT_WIDTH-1:0] RT_CARD1_TX = 6'h1e;
   localparam logic [RT_WIDTH-1:0] RT_CARD1_RX = 6'h1f;
   localparam logic [RT_WIDTH-1:0] RT_SSP1_TX = 6'h20;
   localparam logic [RT_WIDTH-1:0] RT_SSP1_RX = 6'h21;
   localparam logic [RT_WIDTH-1:0] RT_PCM_TX = 6'h22;
   localparam logic [RT_WIDTH-1:0] RT_PCM_RX = 6'h23;

   // Bit positions in the on-chip request vector
   typedef enum int unsigned {
      SRC_NAND, SRC_ECC_ENC, SRC_ECC_DEC, SRC_TS_RX,
      SRC_SER3_TX, SRC_SER3_RX, SRC_SER2_TX, SRC_SER2_RX,
      SRC_SER1_TX, SRC_SER1_RX, SRC_SER0_TX, SRC_SER0_RX,
      SRC_SSP0_TX, SRC_SSP0_RX, SRC_AUD_TX, SRC_AUD_RX,
      SRC_CARD0_TX, SRC_CARD0_RX, SRC_ADC, SRC_CARD1_TX,
      SRC_CARD1_RX, SRC_SSP1_TX, SRC_SSP1_RX, SRC_PCM_TX,
      SRC_PCM_RX, SRC_COUNT
   } src_e;
   localparam int NUM_SOURCES = SRC_COUNT;

   typedef enum logic [1:0] {
      DIR_MEM_TO_MEM = 2'h0,
      DIR_MEM_TO_DEV = 2'h1,
      DIR_DEV_TO_MEM = 2'h2,
      DIR_EITHER = 2'h3
   } dir_e;
endpackage : dma_reqsel_pkg

// file: hdl/dma_request_source_select.sv
`timescale 1ns/1ps
module dma_request_source_select
   import dma_reqsel_pkg::*;
#(
   parameter int NUM_CHANNELS = dma_reqsel_pkg::NUM_CHANNELS_DEFAULT
)
(
   input wire logic clock,
   input wire logic srst,
   input wire logic [NUM_CHANNELS-1:0] rt_write,
   input wire logic [dma_reqsel_pkg::REG_WIDTH-1:0] rt_wdata,
   input wire logic [dma_reqsel_pkg::NUM_SOURCES-1:0] periph_request,
   input wire logic ext_dma_request_pin,
   input wire logic [NUM_CHANNELS-1:0] timer_overflow,
   input wire logic [NUM_CHANNELS-1:0] chan_ack,
   output logic [NUM_CHANNELS-1:0][dma_reqsel_pkg::REG_WIDTH-1:0] rt_readback,
   output logic [NUM_CHANNELS-1:0] chan_request,
   output logic [NUM_CHANNELS-1:0] chan_auto,
   output logic [NUM_CHANNELS-1:0][1:0] chan_dir,
   output logic [NUM_CHANNELS-1:0] chan_periph_fixed,
   output logic [NUM_CHANNELS-1:0] chan_reserved,
   output logic [NUM_CHANNELS-1:0] chan_shared_conflict,
   output logic ext_dma_acknowledge_pin
);
   typedef logic [NUM_CHANNELS-1:0] chan_vec_t;
   typedef logic [NUM_CHANNELS-1:0][RT_WIDTH-1:0] code_vec_t;
   typedef logic [NUM_CHANNELS-1:0][1:0] dir_vec_t;

   typedef struct packed {
      code_vec_t code;
      chan_vec_t settle;
      chan_vec_t request;
      chan_vec_t auto_mode;
      dir_vec_t dir;
      chan_vec_t periph_fixed;
      chan_vec_t reserved;
      chan_vec_t conflict;
      logic ack;
   } state_s;

   state_s state;
   state_s next_state;

   chan_vec_t dec_request;
   chan_vec_t dec_auto;
   dir_e dec_dir [NUM_CHANNELS];
   chan_vec_t dec_fixed;
   chan_vec_t dec_reserved;
   chan_vec_t ext_selected;

   // One decoder per channel looks at the stored code
   for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
      request_code_decoder u_decoder (
         .code(state.code[ch]),
         .periph_request(periph_request),
         .ext_request(ext_dma_request_pin),
         .timer_overflow(timer_overflow[ch]),
         .request(dec_request[ch]),
         .auto_mode(dec_auto[ch]),
         .dir(dec_dir[ch]),
         .periph_fixed(dec_fixed[ch]),
         .reserved(dec_reserved[ch])
      );
      assign ext_selected[ch] = (state.code[ch] == RT_EXT_PIN);
   end

   always_comb begin
      next_state = state;

      // Code store; only the low field is kept, the rest is dropped
      for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
         next_state.settle[ch] = 1'b0;
         if (rt_write[ch]) begin
            next_state.code[ch] = rt_wdata[RT_MSB:RT_LSB];
            // A new code masks the request for a cycle so the old source
            // cannot leak into the new selection
            next_state.settle[ch] = 1'b1;
         end
      end

      // Request presented to the engine, one cycle after the source
      for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
         if (rt_write[ch] || state.settle[ch]) begin
            next_state.request[ch] = 1'b0;
         end else if (dec_reserved[ch]) begin
            next_state.request[ch] = 1'b0;
         end else begin
            next_state.request[ch] = dec_request[ch];
         end
         next_state.auto_mode[ch] = dec_auto[ch];
         next_state.dir[ch] = dec_dir[ch];
         next_state.periph_fixed[ch] = dec_fixed[ch];
         next_state.reserved[ch] = dec_reserved[ch];
      end

      // Flag channels sharing a request type that is neither auto nor reserved
      for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
         next_state.conflict[ch] = 1'b0;
         for (int other = 0; other < NUM_CHANNELS; other++) begin
            if (other != ch && state.code[other] == state.code[ch]
                && !dec_auto[ch] && !dec_reserved[ch]) begin
               next_state.conflict[ch] = 1'b1;
            end
         end
      end

      // External device acknowledged on the unit the engine moves for it
      next_state.ack = |(chan_ack & ext_selected);

      if (srst) begin
         for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
            next_state.code[ch] = RT_RESET;
            next_state.dir[ch] = DIR_MEM_TO_MEM;
         end
         next_state.settle = '0;
         next_state.request = '0;
         next_state.auto_mode = '0;
         next_state.periph_fixed = '0;
         next_state.reserved = '0;
         next_state.conflict = '0;
         next_state.ack = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      state <= next_state;
   end

   // Outputs come straight from the state flops
   always_comb begin
      for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
         rt_readback[ch] = {RT_UPPER_ZERO, state.code[ch]};
      end
   end

   assign chan_request = state.request;
   assign chan_auto = state.auto_mode;
   assign chan_dir = state.dir;
   assign chan_periph_fixed = state.periph_fixed;
   assign chan_reserved = state.reserved;
   assign chan_shared_conflict = state.conflict;
   assign ext_dma_acknowledge_pin = state.ack;
endmodule : dma_request_source_select

// file: hdl/request_code_decoder.sv
`timescale 1ns/1ps
module request_code_decoder
   import dma_reqsel_pkg::*;
(
   input wire logic [RT_WIDTH-1:0] code,
   input wire logic [NUM_SOURCES-1:0] periph_request,
   input wire logic ext_request,
   input wire logic timer_overflow,
   output logic request,
   output logic auto_mode,
   output dma_reqsel_pkg::dir_e dir,
   output logic periph_fixed,
   output logic reserved
);
   always_comb begin
      request = 1'b0;
      auto_mode = 1'b0;
      dir = DIR_MEM_TO_MEM;
      periph_fixed = 1'b1;
      reserved = 1'b0;
      unique case (code)
         RT_EXT_PIN: begin
            request = ext_request;
            dir = DIR_EITHER;
            periph_fixed = 1'b0;
         end
         RT_NAND: begin
            request = periph_request[SRC_NAND];
            periph_fixed = 1'b0;
         end
         RT_ECC_ENC: request = periph_request[SRC_ECC_ENC];
         RT_ECC_DEC: request = periph_request[SRC_ECC_DEC];
         RT_AUTO: begin
            request = 1'b1;
            auto_mode = 1'b1;
            periph_fixed = 1'b0;
         end
         RT_TS_RX: begin
            request = periph_request[SRC_TS_RX];
            dir = DIR_DEV_TO_MEM;
         end
         RT_SER3_TX, RT_SER2_TX, RT_SER1_TX, RT_SER0_TX: begin
            request = periph_request[SRC_SER3_TX + 2 * int'(code - RT_SER3_TX) / 2];
            dir = DIR_MEM_TO_DEV;
         end
         RT_SER3_RX, RT_SER2_RX, RT_SER1_RX, RT_SER0_RX: begin
            request = periph_request[SRC_SER3_RX + 2 * (int'(code - RT_SER3_RX) / 2)];
            dir = DIR_DEV_TO_MEM;
         end
         RT_SSP0_TX: request = periph_request[SRC_SSP0_TX];
         RT_SSP0_RX: request = periph_request[SRC_SSP0_RX];
         RT_AUD_TX: request = periph_request[SRC_AUD_TX];
         RT_AUD_RX: request = periph_request[SRC_AUD_RX];
         RT_CARD0_TX: request = periph_request[SRC_CARD0_TX];
         RT_CARD0_RX: request = periph_request[SRC_CARD0_RX];
         RT_TIMER: begin
            request = timer_overflow;
            periph_fixed = 1'b0;
         end
         RT_ADC: begin
            request = periph_request[SRC_ADC];
            dir = DIR_DEV_TO_MEM;
         end
         RT_CARD1_TX: request = periph_request[SRC_CARD1_TX];
         RT_CARD1_RX: request = periph_request[SRC_CARD1_RX];
         RT_SSP1_TX: request = periph_request[SRC_SSP1_TX];
         RT_SSP1_RX: request = periph_request[SRC_SSP1_RX];
         RT_PCM_TX: request = periph_request[SRC_PCM_TX];
         RT_PCM_RX: request = periph_request[SRC_PCM_RX];
         default: begin
            reserved = 1'b1;
            periph_fixed = 1'b0;
         end
      endcase
      // Direction of the paired on-chip FIFO requests follows the low code bit
      if (!reserved && periph_fixed && dir == DIR_MEM_TO_MEM) begin
         dir = code[0] ? DIR_DEV_TO_MEM : DIR_MEM_TO_DEV;
      end
      if (!reserved && (code == RT_NAND || code == RT_TIMER)) begin
         dir = DIR_MEM_TO_MEM;
      end
   end
endmodule : request_code_decoder

// file: testbench/dma_reqsel_checker.sv
`timescale 1ns/1ps
module dma_reqsel_checker
   import dma_reqsel_pkg::*;
#(
   parameter int NUM_CHANNELS = 6
)
(
   input wire logic clock,
   input wire logic srst,
   input wire logic [NUM_CHANNELS-1:0] rt_write,
   input wire logic [dma_reqsel_pkg::REG_WIDTH-1:0] rt_wdata,
   input wire logic [dma_reqsel_pkg::NUM_SOURCES-1:0] periph_request,
   input wire logic ext_dma_request_pin,
   input wire logic [NUM_CHANNELS-1:0] timer_overflow,
   input wire logic [NUM_CHANNELS-1:0] chan_ack,
   input wire logic [NUM_CHANNELS-1:0][dma_reqsel_pkg::REG_WIDTH-1:0] rt_readback,
   input wire logic [NUM_CHANNELS-1:0] chan_request,
   input wire logic [NUM_CHANNELS-1:0] chan_auto,
   input wire logic [NUM_CHANNELS-1:0][1:0] chan_dir,
   input wire logic [NUM_CHANNELS-1:0] chan_reserved,
   input wire logic ext_dma_acknowledge_pin
);
   logic [5:0] code;
   logic [1:0] gap;
   logic settled, ack_hit, rsv;
   int src;
   assign code = rt_readback[0][5:0];
   // Request is masked for two cycles after a write
   assign settled = gap != 2'h0 && !rt_write[0];
   assign rsv = src < 0 && !(code inside {6'h00, 6'h08, 6'h1c});
   always_ff @(posedge clock) begin
      if (srst || rt_write[0]) gap <= 2'h0;
      else if (gap != 2'h3) gap <= gap + 2'h1;
   end
   always_comb begin
      ack_hit = 1'h0;
      for (int i = 0; i < NUM_CHANNELS; i++) ack_hit |= chan_ack[i] && rt_readback[i][5:0] == 6'h00;
      src = -1;
      if (code inside {[6'h01:6'h03]}) src = int'(code) - 1;
      if (code == RT_TS_RX) src = SRC_TS_RX;
      if (code inside {[6'h0e:6'h1b]}) src = int'(code) - 10;
      if (code inside {[6'h1d:6'h23]}) src = int'(code) - 11;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   upper_zero_a: assert property (rt_readback[0][31:6] == 26'h000_0000)
      else $error("readback upper bits not zero");
   code_store_a: assert property (rt_write[0] |=> code == $past(rt_wdata[5:0]))
      else $error("code not stored");
   ext_track_a: assert property (settled && code == RT_EXT_PIN |=>
      chan_request[0] == $past(ext_dma_request_pin)) else $error("ext request not followed");
   periph_track_a: assert property (settled && src >= 0 |=>
      chan_request[0] == $past(periph_request[src])) else $error("peripheral not followed");
   auto_self_a: assert property (settled && code == RT_AUTO |=>
      chan_request[0] && chan_auto[0]) else $error("auto request missing");
   timer_track_a: assert property (settled && code == RT_TIMER |=>
      chan_request[0] == $past(timer_overflow[0]) && chan_dir[0] == DIR_MEM_TO_MEM)
      else $error("timer not followed");
   reserved_quiet_a: assert property (rsv && !rt_write[0] |=>
      !chan_request[0] && chan_reserved[0]) else $error("reserved code requested");
   ack_follow_a: assert property (ack_hit |=> ext_dma_acknowledge_pin)
      else $error("acknowledge missing");
   ack_quiet_a: assert property (!ack_hit |=> !ext_dma_acknowledge_pin)
      else $error("stray acknowledge");
   adc_dir_a: assert property (code == RT_ADC && !rt_write[0] |=>
      chan_dir[0] == DIR_DEV_TO_MEM) else $error("converter direction wrong");
   cover property (settled && code == RT_AUTO);
   cover property (ack_hit ##1 ext_dma_acknowledge_pin);
   cover property (rsv && chan_reserved[0]);
endmodule : dma_reqsel_checker
bind dma_request_source_select dma_reqsel_checker #(.NUM_CHANNELS(NUM_CHANNELS)) chk (
   .clock, .srst, .rt_write, .rt_wdata, .periph_request, .ext_dma_request_pin,
   .timer_overflow, .chan_ack, .rt_readback, .chan_request, .chan_auto, .chan_dir,
   .chan_reserved, .ext_dma_acknowledge_pin);

// file: testbench/req_source_model.sv
`timescale 1ns/1ps
module req_source_model #(
   parameter int NCH = 6
)
(
   input wire logic clock,
   input wire logic [25+NCH:0] pattern,
   input wire logic ack_pin,
   output logic [24:0] periph,
   output logic ext_req,
   output logic [NCH-1:0] tmr
);
   logic acked = 1'h0;
   initial {periph, ext_req, tmr} = '0;
   // Levels move just after the edge, as a registered peripheral would
   always @(posedge clock) begin
      periph <= #1 pattern[24:0];
      tmr <= #1 pattern[25+NCH:26];
      // Device drops its request once acknowledged
      acked <= pattern[25] & (acked | ack_pin);
      ext_req <= #1 pattern[25] & ~(acked | ack_pin);
   end
endmodule : req_source_model

// file: testbench/tb_dma_request_source_select.sv
`timescale 1ns/1ps
module tb_dma_request_source_select;
   import dma_reqsel_pkg::*;
   localparam int NCH = 6;
   typedef struct {int cyc; int what; int ch; logic [31:0] val;} note_s;
   logic clock = 1'h0;
   logic srst = 1'h1;
   logic [NCH-1:0] rt_write = '0;
   logic [31:0] rt_wdata = '0;
   logic [NCH-1:0] chan_ack = '0;
   logic [25+NCH:0] pattern = '0;
   logic [24:0] periph;
   logic ext_req, ack_pin;
   logic [NCH-1:0] tmr, req, auto_f, rsv_f, conf, fix_f;
   logic [NCH-1:0][1:0] dir_f;
   logic [NCH-1:0][31:0] rb;
   note_s q[$];
   int cyc = 0, n_fail = 0, compares = 0, seed = 32'h0541;
   dma_request_source_select #(.NUM_CHANNELS(NCH)) uut (.clock, .srst, .rt_write, .rt_wdata,
      .periph_request(periph), .ext_dma_request_pin(ext_req), .timer_overflow(tmr),
      .chan_ack, .rt_readback(rb), .chan_request(req), .chan_auto(auto_f), .chan_dir(dir_f),
      .chan_periph_fixed(fix_f), .chan_reserved(rsv_f), .chan_shared_conflict(conf),
      .ext_dma_acknowledge_pin(ack_pin));
   req_source_model #(.NCH(NCH)) src_model (.clock, .pattern, .ack_pin, .periph, .ext_req, .tmr);
   always #50 clock = ~clock;
   task automatic end_sim();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   // Cycle ceiling well above the sweep length
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         end_sim();
      end
   end
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   always @(negedge clock) begin
      while (q.size() > 0 && q[0].cyc == cyc) begin
         note_s n;
         n = q.pop_front();
         case (n.what)
            0: check("request", 32'(req[n.ch]), n.val);
            1: check("readback", rb[n.ch], n.val);
            2: check("ack", 32'(ack_pin), n.val);
            3: check("reserved", 32'(rsv_f[n.ch]), n.val);
            4: check("auto", 32'(auto_f[n.ch]), n.val);
            5: check("conflict", 32'(conf[n.ch]), n.val);
            6: check("dir", 32'(dir_f[n.ch]), n.val);
            default: check("fixed", 32'(fix_f[n.ch]), n.val);
         endcase
      end
   end
   task automatic tick();
      @(posedge clock);
      #1;
   endtask : tick
   task automatic note(int dt, int what, int ch, logic [31:0] v);
      q.push_back(note_s'{cyc + dt, what, ch, v});
   endtask : note
   task automatic write(int ch, logic [5:0] code);
      rt_write[ch] = 1'h1;
      rt_wdata = {26'($random(seed)), code};
      note(1, 1, ch, 32'(code));
      tick();
      rt_write = '0;
   endtask : write
   function automatic logic exp_req(logic [5:0] c, logic [25+NCH:0] p);
      case (c) inside
         6'h00: return p[25];
         [6'h01:6'h03]: return p[c - 6'h01];
         6'h08: return 1'h1;
         6'h09: return p[3];
         [6'h0e:6'h1b]: return p[c - 6'h0a];
         6'h1c: return p[26];
         [6'h1d:6'h23]: return p[c - 6'h0b];
         default: return 1'h0;
      endcase
   endfunction : exp_req
   // Paired FIFO codes: even is toward the device, odd is from it
   function automatic logic [1:0] exp_dir(int c);
      if (c == 0) return 2'h3;
      if (!(c inside {[2:3], 9, [14:27], [29:35]})) return 2'h0;
      if (c == 9 || c == 29) return 2'h2;
      return c[0] ? 2'h2 : 2'h1;
   endfunction : exp_dir
   initial begin
      repeat (20) tick();
      srst = 1'h0;
      tick();
      for (int ch = 0; ch < NCH; ch++) note(0, 1, ch, 32'h0000_0000);
      for (int ch = 1; ch < NCH; ch++) write(ch, RT_AUTO);
      // Every code on channel 0, random source levels held past the mask
      for (int c = 0; c < 64; c++) begin
         write(0, 6'(c));
         repeat (2) begin
            pattern = 32'($random(seed));
            note(3, 0, 0, 32'(exp_req(6'(c), pattern)));
            note(3, 3, 0, 32'(!(c inside {[0:3], 8, 9, [14:35]})));
            note(3, 4, 0, 32'(c == 8));
            note(3, 6, 0, 32'(exp_dir(c)));
            note(3, 7, 0, 32'(c inside {[2:3], 9, [14:27], [29:35]}));
            repeat (3) tick();
         end
         chan_ack[0] = 1'h1;
         note(1, 2, 0, 32'(c == 0));
         tick();
         chan_ack = '0;
         pattern = '0;
         tick();
      end
      // Shared code flagged, shared auto not
      write(3, RT_AUD_RX);
      write(0, RT_AUD_RX);
      note(2, 5, 0, 32'h0000_0001);
      note(2, 5, 1, 32'h0000_0000);
      note(2, 5, 3, 32'h0000_0001);
      repeat (3) tick();
      srst = 1'h1;
      repeat (2) tick();
      srst = 1'h0;
      tick();
      note(0, 1, 0, 32'h0000_0000);
      tick();
      if (q.size() != 0) n_fail++;
      end_sim();
   end
endmodule : tb_dma_request_source_select
